// ===== vfq_defines.vh
// constants for the output fault qualifier and external temperature trim block
`ifndef VFQ_DEFINES_VH
`define VFQ_DEFINES_VH
`define VFQ_CMD_FAULT_CFG    8'hd8
`define VFQ_CMD_TEMP_GAIN    8'hd9
`define VFQ_CMD_TEMP_TRIM    8'hda
`define VFQ_RST_FAULT_CFG    8'h00
`define VFQ_RST_TEMP_GAIN    16'hba00
`define VFQ_RST_TEMP_TRIM    16'h0000
`define VFQ_CFG_LOWSIDE_BIT  7
`define VFQ_CFG_CNT_MSB      3
`define VFQ_CFG_USED_MASK    8'h8f
`define VFQ_MAN_MSB          10
`define VFQ_EXP_LSB          11
`define VFQ_EXP_BIAS         5'h10
// linear values scaled by 2^16 for range checks
`define VFQ_GAIN_MIN         48'h0000_0000_199a
`define VFQ_GAIN_MAX         48'h0000_000a_0000
`define VFQ_TRIM_MAX         48'h0000_0064_0000
`define VFQ_TRIM_TO_Q4       12
`define VFQ_QUOT_FRAC        15
`define VFQ_DIV_W            47
`define VFQ_DIV_CNT          6'h2f
`define VFQ_DEN_W            10
`define VFQ_POS_MAX          18'h0_7fff
`define VFQ_NEG_MIN          18'h3_8000
`endif

// ===== vfq_div.v
// serial restoring divider, one quotient bit per enabled clock
`timescale 1ns/100ps
module vfq_div
(
	input  wire                    ref_clk_i,
	input  wire                    rst_i,
	input  wire                    ce_i,
	input  wire                    start_i,
	input  wire [46:0]             num_i,
	input  wire [9:0]              den_i,
	output reg                     busy_o,
	output reg                     done_o,
	output reg  [46:0]             quot_o
);
`include "vfq_defines.vh"
	reg  [46:0]  num;
	reg  [10:0]  rem;
	reg  [5:0]   cnt;
	wire [10:0]  trial = {rem[9:0], num[46]};
	wire         fits  = trial >= {1'b0, den_i};

	always @(posedge ref_clk_i)
	begin
		if (rst_i)
		begin
			busy_o <= 1'b0;
			done_o <= 1'b0;
			quot_o <= 47'h0000_0000_0000;
			num    <= 47'h0000_0000_0000;
			rem    <= 11'h000;
			cnt    <= 6'h00;
		end
		else if (ce_i)
		begin
			done_o <= 1'b0;
			if (start_i && !busy_o)
			begin
				busy_o <= 1'b1;
				num    <= num_i;
				rem    <= 11'h000;
				cnt    <= `VFQ_DIV_CNT;
			end
			else if (busy_o)
			begin
				rem    <= fits ? trial - {1'b0, den_i} : trial;
				num    <= {num[45:0], fits};
				cnt    <= cnt - 6'h01;
				if (cnt == 6'h01)
				begin
					busy_o <= 1'b0;
					done_o <= 1'b1;
					quot_o <= {num[45:0], fits};
				end
			end
		end
	end
endmodule // vfq_div

// ===== vfq_top.v
// output fault qualifier and external temperature gain/offset trim
`timescale 1ns/100ps
module vfq_top
(
	input  wire        ref_clk_i,
	input  wire        rst_i,
	input  wire        ce_i,
	input  wire        wr_i,
	input  wire        rd_i,
	input  wire [7:0]  cmd_i,
	input  wire [15:0] wdata_i,
	output reg  [15:0] rdata_o,
	output reg         rd_valid_o,
	output reg         cmd_err_o,
	output reg         range_err_o,
	input  wire        check_i,
	input  wire        ov_viol_i,
	input  wire        uv_viol_i,
	output reg         ov_fault_o,
	output reg         uv_fault_o,
	output reg         lowside_on_o,
	input  wire        meas_valid_i,
	input  wire        meas_phase_i,
	input  wire [15:0] meas_temp_i,
	output reg  [15:0] ext_temp_value0_o,
	output reg  [15:0] ext_temp_value1_o,
	output reg         temp_upd_o
);
`include "vfq_defines.vh"
	reg  [7:0]   output_fault_config;
	reg  [15:0]  ext_temp_gain;
	reg  [15:0]  ext_temp_trim;

	// magnitude of a linear word, scaled by 2^16
	function [47:0] lin_mag;
		input [15:0] w;
		reg   [9:0]  m;
		reg   [4:0]  sh;
		begin
			m       = w[`VFQ_MAN_MSB] ? 10'h000 - w[9:0] : w[9:0];
			if (w[`VFQ_MAN_MSB] && w[9:0] == 10'h000)
				m   = 10'h3ff;
			sh      = w[15:`VFQ_EXP_LSB] + `VFQ_EXP_BIAS;
			lin_mag = {38'h00_0000_0000, m} << sh;
		end
	endfunction

	////////////////////////////////////////////////////////////////////////
	// register access
	wire [47:0] wr_mag   = lin_mag(wdata_i);
	wire        wr_neg   = wdata_i[`VFQ_MAN_MSB];
	wire        gain_ok  = !wr_neg && wr_mag >= `VFQ_GAIN_MIN && wr_mag <= `VFQ_GAIN_MAX;
	wire        trim_ok  = wr_mag <= `VFQ_TRIM_MAX;
	wire        hit      = cmd_i == `VFQ_CMD_FAULT_CFG || cmd_i == `VFQ_CMD_TEMP_GAIN
			    || cmd_i == `VFQ_CMD_TEMP_TRIM;

	always @(posedge ref_clk_i)
	begin
		if (rst_i)
		begin
			output_fault_config <= `VFQ_RST_FAULT_CFG;
			ext_temp_gain       <= `VFQ_RST_TEMP_GAIN;
			ext_temp_trim       <= `VFQ_RST_TEMP_TRIM;
			rdata_o             <= 16'h0000;
			rd_valid_o          <= 1'b0;
			cmd_err_o           <= 1'b0;
			range_err_o         <= 1'b0;
		end
		else if (ce_i)
		begin
			rd_valid_o  <= rd_i;
			cmd_err_o   <= (rd_i || wr_i) && !hit;
			range_err_o <= 1'b0;
			if (wr_i)
			begin
				case (cmd_i)
				`VFQ_CMD_FAULT_CFG: output_fault_config <= wdata_i[7:0] & `VFQ_CFG_USED_MASK;
				`VFQ_CMD_TEMP_GAIN:
				begin
					if (gain_ok)
						ext_temp_gain <= wdata_i;
					else
						range_err_o   <= 1'b1;
				end
				`VFQ_CMD_TEMP_TRIM:
				begin
					if (trim_ok)
						ext_temp_trim <= wdata_i;
					else
						range_err_o   <= 1'b1;
				end
				default: ;
				endcase
			end
			if (rd_i)
			begin
				case (cmd_i)
				`VFQ_CMD_FAULT_CFG: rdata_o <= {8'h00, output_fault_config};
				`VFQ_CMD_TEMP_GAIN: rdata_o <= ext_temp_gain;
				`VFQ_CMD_TEMP_TRIM: rdata_o <= ext_temp_trim;
				default:            rdata_o <= 16'h0000;
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// consecutive violation qualifier, ov is channel 0, uv channel 1
	wire [1:0]  viol = {uv_viol_i, ov_viol_i};
	wire [4:0]  lim  = {1'b0, output_fault_config[`VFQ_CFG_CNT_MSB:0]} + 5'h01;
	wire [1:0]  next_fault;
	genvar ch;
	generate
		for (ch = 0; ch < 2; ch = ch + 1)
		begin : g_qual
			reg  [4:0] cnt;
			wire [4:0] next_cnt = !check_i ? cnt :
					      !viol[ch] ? 5'h00 :
					      (cnt >= lim) ? lim : cnt + 5'h01;
			// fault only at n+1 consecutive violations
			assign next_fault[ch] = next_cnt >= lim;
			always @(posedge ref_clk_i)
			begin
				if (rst_i)
					cnt <= 5'h00;
				else if (ce_i)
					cnt <= next_cnt;
			end
		end
	endgenerate

	always @(posedge ref_clk_i)
	begin
		if (rst_i)
		begin
			ov_fault_o   <= 1'b0;
			uv_fault_o   <= 1'b0;
			lowside_on_o <= 1'b0;
		end
		else if (ce_i)
		begin
			ov_fault_o   <= next_fault[0];
			uv_fault_o   <= next_fault[1];
			// low-side switch on ov shutdown only if enabled
			lowside_on_o <= next_fault[0] & output_fault_config[`VFQ_CFG_LOWSIDE_BIT];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// temperature trim: temp / gain + offset, one sample at a time
	reg         phase;
	reg         t_neg;
	reg  [46:0] div_num;
	reg         div_go;
	wire        div_busy;
	wire        div_done;
	wire [46:0] quot;
	wire [15:0] t_mag    = meas_temp_i[15] ? 16'h0000 - meas_temp_i : meas_temp_i;
	wire [4:0]  g_sh     = ext_temp_gain[15:`VFQ_EXP_LSB] + `VFQ_EXP_BIAS;
	// gain is always positive, so its mantissa is the divisor
	wire [9:0]  g_man    = ext_temp_gain[9:0];
	wire [31:0] q_hi     = quot[46:`VFQ_QUOT_FRAC];
	wire [14:0] q_sat    = (q_hi > 32'h0000_7fff) ? 15'h7fff : q_hi[14:0];
	wire [17:0] q_s      = t_neg ? 18'h0_0000 - {3'h0, q_sat} : {3'h0, q_sat};
	wire [47:0] o_q4     = lin_mag(ext_temp_trim) >> `VFQ_TRIM_TO_Q4;
	wire [17:0] o_abs    = o_q4[17:0];
	wire [17:0] o_s      = ext_temp_trim[`VFQ_MAN_MSB] ? 18'h0_0000 - o_abs : o_abs;
	wire [17:0] sum      = q_s + o_s;
	wire        sum_neg  = sum[17];
	wire [15:0] sum_sat  = (!sum_neg && sum > `VFQ_POS_MAX) ? 16'h7fff :
			       (sum_neg && sum < `VFQ_NEG_MIN) ? 16'h8000 : sum[15:0];

	always @(posedge ref_clk_i)
	begin
		if (rst_i)
		begin
			phase             <= 1'b0;
			t_neg             <= 1'b0;
			div_num           <= 47'h0000_0000_0000;
			div_go            <= 1'b0;
			ext_temp_value0_o <= 16'h0000;
			ext_temp_value1_o <= 16'h0000;
			temp_upd_o        <= 1'b0;
		end
		else if (ce_i)
		begin
			div_go     <= 1'b0;
			temp_upd_o <= 1'b0;
			// samples arriving during a division are dropped, not queued
			if (meas_valid_i && !div_busy && !div_go)
			begin
				phase   <= meas_phase_i;
				t_neg   <= meas_temp_i[15];
				div_num <= {t_mag, 31'h0000_0000} >> g_sh;
				div_go  <= 1'b1;
			end
			if (div_done)
			begin
				// both channels share gain and offset
				if (phase)
					ext_temp_value1_o <= sum_sat;
				else
					ext_temp_value0_o <= sum_sat;
				temp_upd_o <= 1'b1;
			end
		end
	end

	vfq_div u_div
	(
		.ref_clk_i (ref_clk_i),
		.rst_i     (rst_i),
		.ce_i      (ce_i),
		.start_i   (div_go),
		.num_i     (div_num),
		.den_i     (g_man),
		.busy_o    (div_busy),
		.done_o    (div_done),
		.quot_o    (quot)
	);
endmodule // vfq_top

// ===== vfq_checker.sv
// concurrent checks on the fault qualifier and trim block ports
`timescale 1ns/100ps
module vfq_checker
(
	input wire        ref_clk_i,
	input wire        rst_i,
	input wire        ce_i,
	input wire        wr_i,
	input wire        rd_i,
	input wire [7:0]  cmd_i,
	input wire [15:0] wdata_i,
	input wire [15:0] rdata_o,
	input wire        rd_valid_o,
	input wire        cmd_err_o,
	input wire        range_err_o,
	input wire        check_i,
	input wire        ov_viol_i,
	input wire        uv_viol_i,
	input wire        ov_fault_o,
	input wire        uv_fault_o,
	input wire        lowside_on_o,
	input wire        meas_valid_i,
	input wire        temp_upd_o
);
default clocking @(posedge ref_clk_i); endclocking
default disable iff (rst_i);
////////////////////////////////////////////////////////////////////////////////
property p_rd; ce_i && rd_i && cmd_i == 8'hd8 |=> rd_valid_o && rdata_o[6:4] == 3'h0; endproperty
a_rd: assert property (p_rd) else $error("config read wrong");
property p_bad; ce_i && (rd_i || wr_i) && cmd_i > 8'hda |=> cmd_err_o; endproperty
a_bad: assert property (p_bad) else $error("unmapped code not flagged");
property p_gain; ce_i && wr_i && cmd_i == 8'hd9 && wdata_i == 16'h0000 |=> range_err_o; endproperty
a_gain: assert property (p_gain) else $error("zero gain accepted");
property p_trim; ce_i && wr_i && cmd_i == 8'hda && wdata_i == 16'h0065 |=> range_err_o; endproperty
a_trim: assert property (p_trim) else $error("offset above range accepted");
property p_rise; $rose(ov_fault_o) |-> $past(check_i && ov_viol_i); endproperty
a_rise: assert property (p_rise) else $error("fault without violated check");
property p_ovclr; ce_i && check_i && !ov_viol_i |=> !ov_fault_o; endproperty
a_ovclr: assert property (p_ovclr) else $error("ov fault survives clean check");
property p_uvclr; ce_i && check_i && !uv_viol_i |=> !uv_fault_o; endproperty
a_uvclr: assert property (p_uvclr) else $error("uv fault survives clean check");
property p_low; lowside_on_o |-> ov_fault_o; endproperty
a_low: assert property (p_low) else $error("low side on without ov fault");
// value lands at the 49th edge after the taking edge, seen one edge later
property p_upd; temp_upd_o |-> $past(meas_valid_i, 50); endproperty
a_upd: assert property (p_upd) else $error("update without sample");
endmodule // vfq_checker
bind vfq_top vfq_checker chk (.ref_clk_i, .rst_i, .ce_i, .wr_i, .rd_i, .cmd_i, .wdata_i,
	.rdata_o, .rd_valid_o, .cmd_err_o, .range_err_o, .check_i, .ov_viol_i, .uv_viol_i,
	.ov_fault_o, .uv_fault_o, .lowside_on_o, .meas_valid_i, .temp_upd_o);

// ===== vfq_host.sv
// host model issuing command strobes
`timescale 1ns/100ps
module vfq_host
(
	input  wire        ref_clk_i,
	input  wire        cmd_err_i,
	input  wire        range_err_i,
	output reg         wr_o = 1'b0,
	output reg         rd_o = 1'b0,
	output reg  [7:0]  cmd_o = 8'h00,
	output reg  [15:0] wdata_o = 16'h0000
);
task acc(input logic w, input logic [7:0] c, input logic [15:0] d, output logic [1:0] err);
	@(posedge ref_clk_i);
	wr_o <= w;
	rd_o <= !w;
	cmd_o <= c;
	wdata_o <= d;
	@(posedge ref_clk_i);
	wr_o <= 1'b0;
	rd_o <= 1'b0;
	// released lines flip so stale data never looks valid
	cmd_o <= ~c;
	wdata_o <= ~d;
	#1;
	err = {cmd_err_i, range_err_i};
endtask
endmodule // vfq_host

// ===== vfq_top_test.sv
// self-checking bench for the fault qualifier and trim block
`timescale 1ns/100ps
module vfq_top_test;
logic        ref_clk_i, rst_i, ce_i, check_i, ov_viol_i, uv_viol_i, meas_valid_i, meas_phase_i;
logic        wr_i, rd_i, rd_valid_o, cmd_err_o, range_err_o;
logic        ov_fault_o, uv_fault_o, lowside_on_o, temp_upd_o;
logic [7:0]  cmd_i;
logic [15:0] wdata_i, rdata_o, meas_temp_i, ext_temp_value0_o, ext_temp_value1_o;
logic [16:0] rq[$], tq[$], re, te;
int          errors, num_checks, cyc, t;
vfq_host host (.ref_clk_i, .cmd_err_i(cmd_err_o), .range_err_i(range_err_o), .wr_o(wr_i),
	.rd_o(rd_i), .cmd_o(cmd_i), .wdata_o(wdata_i));
vfq_top dut (.ref_clk_i, .rst_i, .ce_i, .wr_i, .rd_i, .cmd_i, .wdata_i, .rdata_o, .rd_valid_o,
	.cmd_err_o, .range_err_o, .check_i, .ov_viol_i, .uv_viol_i, .ov_fault_o, .uv_fault_o,
	.lowside_on_o, .meas_valid_i, .meas_phase_i, .meas_temp_i, .ext_temp_value0_o,
	.ext_temp_value1_o, .temp_upd_o);
////////////////////////////////////////////////////////////////////////////////
task cmp(input string n, input logic [15:0] e, input logic [15:0] g);
	num_checks++;
	if (g !== e)
	begin
		errors++;
		$display("MISMATCH %s expected %h seen %h", n, e, g);
	end
endtask
task tally_and_finish;
	$display("checks %0d errors %0d", num_checks, errors);
	if (errors == 0 && num_checks > 0)
		$display("SIMULATION PASSED");
	else
		$display("SIMULATION FAILED");
	$finish;
endtask
task rd(input logic [7:0] c, input logic [16:0] e);
	logic [1:0] er;
	rq.push_back(e);
	host.acc(1'b0, c, 16'h0000, er);
endtask
task wr(input logic [7:0] c, input logic [15:0] d, input logic [1:0] e);
	logic [1:0] er;
	host.acc(1'b1, c, d, er);
	cmp("write_flags", {14'h0, e}, {14'h0, er});
endtask
task chk(input int n, input logic ov, input logic uv, input logic [2:0] e);
	repeat (n)
	begin
		@(posedge ref_clk_i);
		check_i <= 1'b1;
		ov_viol_i <= ov;
		uv_viol_i <= uv;
	end
	@(posedge ref_clk_i);
	check_i <= 1'b0;
	#1;
	cmp("fault", {13'h0, e}, {13'h0, ov_fault_o, uv_fault_o, lowside_on_o});
endtask
task ms(input logic ph, input logic [15:0] v, input logic [15:0] e);
	tq.push_back({ph, e});
	@(posedge ref_clk_i);
	meas_valid_i <= 1'b1;
	meas_phase_i <= ph;
	meas_temp_i <= v;
	@(posedge ref_clk_i);
	meas_valid_i <= 1'b0;
	meas_temp_i <= ~v;
	wait (tq.size() == 0);
endtask
////////////////////////////////////////////////////////////////////////////////
initial
begin
	ref_clk_i = 1'b0;
	forever #2 ref_clk_i = ~ref_clk_i;
end
always @(posedge ref_clk_i)
begin
	cyc++;
	if (rd_valid_o)
	begin
		re = rq.pop_front();
		cmp("read_data", re[15:0], rdata_o);
		cmp("read_cmd_err", {15'h0, re[16]}, {15'h0, cmd_err_o});
	end
	if (temp_upd_o)
	begin
		te = tq.pop_front();
		cmp("temp_value", te[15:0], te[16] ? ext_temp_value1_o : ext_temp_value0_o);
	end
	if (cyc == 3000)
	begin
		errors++;
		tally_and_finish();
	end
end
initial
begin
	// clock enable high until the freeze scenario near the end
	{rst_i, ce_i} = 2'b11;
	{check_i, ov_viol_i, uv_viol_i, meas_valid_i, meas_phase_i} = 5'h00;
	meas_temp_i = 16'h0000;
	void'($urandom(32'hcf9af513));
	repeat (5) @(posedge ref_clk_i);
	rst_i <= 1'b0;
	rd(8'hd8, 17'h0_0000);
	rd(8'hd9, 17'h0_ba00);
	rd(8'hda, 17'h0_0000);
	wr(8'hd8, 16'h00ff, 2'b00);
	rd(8'hd8, 17'h0_008f);
	wr(8'hdb, 16'h1234, 2'b10);
	rd(8'hdb, 17'h1_0000);
	wr(8'hd9, 16'h0000, 2'b01);
	wr(8'hd9, 16'ha8cc, 2'b01);
	wr(8'hd9, 16'h000b, 2'b01);
	wr(8'hd9, 16'ha8cd, 2'b00);
	wr(8'hd9, 16'h000a, 2'b00);
	rd(8'hd9, 17'h0_000a);
	wr(8'hda, 16'h0065, 2'b01);
	wr(8'hda, 16'h0064, 2'b00);
	rd(8'hda, 17'h0_0064);
	wr(8'hd9, 16'h0801, 2'b00);
	wr(8'hda, 16'hf802, 2'b00);
	ms(1'b1, 16'h00a0, 16'h0060);
	ms(1'b0, 16'hff60, 16'hffc0);
	repeat (4)
	begin
		t = int'($urandom_range(1600)) - 800;
		ms(1'($urandom), 16'(t), 16'(t / 2 + 16));
	end
	wr(8'hd8, 16'h0082, 2'b00);
	chk(2, 1'b1, 1'b0, 3'b000);
	chk(1, 1'b1, 1'b0, 3'b101);
	chk(1, 1'b0, 1'b0, 3'b000);
	wr(8'hd8, 16'h0002, 2'b00);
	chk(3, 1'b1, 1'b1, 3'b110);
	// clock enable low: a write strobe must leave the register untouched
	@(posedge ref_clk_i);
	ce_i <= 1'b0;
	wr(8'hd8, 16'h008f, 2'b00);
	@(posedge ref_clk_i);
	ce_i <= 1'b1;
	rd(8'hd8, 17'h0_0002);
	repeat (2) @(posedge ref_clk_i);
	cmp("pending_reads", 16'h0000, 16'(rq.size()));
	tally_and_finish();
end
endmodule // vfq_top_test
